//--- logic/faco_pkg.sv
// Purpose: shared constants and types for the float convert-op ALU slice
// Assumes: 40-bit extended float operands (sign, 8-bit exponent, 31-bit fraction)
// Notes: fixed-point results sit in bits 39:8, extension bits 7:0
package faco_pkg;

  // ----------------------------------------
  // widths and encodings
  // ----------------------------------------
  localparam int REG_W = 40;
  localparam int FIX_W = 32;
  localparam logic [7:0] EXP_INF = 8'hFF;
  localparam logic [7:0] EXP_LARGEST_NORMAL_VALUE = 8'hFE;
  localparam logic [30:0] FRAC_LARGEST_NORMAL_VALUE = 31'h7FFF_FF00;
  localparam logic [9:0] EXP_BIAS = 10'h07F;
  localparam logic [9:0] FIX_OVF_EXP = 10'h09D;
  localparam logic [REG_W-1:0] ALL_ONES = 40'hFF_FFFF_FFFF;
  localparam logic [FIX_W-1:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [FIX_W-1:0] SAT_NEG = 32'h8000_0000;
  localparam logic [REG_W-1:0] NEG_UNDER_TRUNC = 40'hFF_FFFF_FF00;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [REG_W-1:0] RESULT_RST = 40'h00_0000_0000;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [3:0] STICKY_RST = 4'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [4:0] {
    FACO_OP_RND = 5'h01,
    FACO_OP_SCALB = 5'h02,
    FACO_OP_MANT = 5'h04,
    FACO_OP_LOGB = 5'h08,
    FACO_OP_FIX = 5'h10
  } faco_op_e;

  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [30:0] frac;
  } faco_fp_s;

  typedef struct packed {
    logic carry_flag;
    logic invalid_flag;
    logic negative_flag;
    logic sign_flag;
    logic overflow_flag;
    logic zero_flag;
  } faco_flags_s;

  typedef struct packed {
    logic sticky_underflow;
    logic sticky_fixed_overflow;
    logic sticky_invalid;
    logic sticky_overflow;
  } faco_sticky_s;

  typedef struct packed {
    logic [REG_W-1:0] result;
    logic valid;
    faco_flags_s flags;
    faco_sticky_s sticky;
  } faco_state_s;

endpackage

//--- logic/faco_top.sv
// Purpose: single-cycle float ALU slice for rnd, scalb, mant, logb and fix
// Assumes: operands and mode bits come from logic on clk_sys; no synchronisers
// Notes: result and flags update together one edge after op_valid
//
// What this block does
// - rnd rounds to a 32-bit float, nearest or truncate by boundary select bit.
// - rnd overflow gives signed infinity when nearest, signed largest normal when truncating.
// - denormal inputs act as signed zero; NaN inputs give all ones.
// - rnd sets overflow above exponent +127 and zero on a signed-zero result.
// - scalb adds integer from second operand to exponent; overflow and denormal handled.
// - scalb sets zero when unbiased exponent below -126 or result zero.
// - scalb sets overflow when unbiased exponent above +127.
// - mant gives hidden bit plus fraction, unsigned 1.31 left-justified, never rounded.
// - mant gives all ones for NaN or infinity; overflow only on infinity; negative cleared.
// - mant sign flag follows input sign; zero flag follows zero result.
// - logb gives stored exponent minus 127 as integer in the fixed field.
// - logb without saturation: infinity gives float +inf, zero gives float -inf.
// - logb with saturation: infinity gives 7FFFFFFF, zero gives 80000000.
// - logb overflow on infinity or zero input; negative and zero follow result.
// - fix converts to 32-bit integer, rounding toward minus infinity when truncate bit set, else nearest.
// - fix result right-justified in fixed field, extension byte zero.
// - fix with saturation clamps overflow and infinities to 7FFFFFFF or 80000000.
// - fix without saturation gives all ones on infinity or overflow; NaN gives all ones.
// - fix underflow gives zero, except negative under truncation gives minus one.
// - fix overflow flag when exponent above 157, rounded magnitude beyond the signed 32-bit range, or input infinite.
// - fix invalid on NaN, or unsaturated infinity or overflow; negative and zero follow.
// - sticky bits latch invalid, overflow (not fix) and scalb zero.
`timescale 1ns/1ps
module faco_top
  import faco_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic op_valid,
  input wire faco_op_e op_code,
  input wire logic [REG_W-1:0] opnd_x,
  input wire logic [REG_W-1:0] opnd_y,
  input wire logic round_boundary_sel,
  input wire logic round_to_zero_sel,
  input wire logic alu_saturate_en,
  input wire logic sticky_clr,
  output logic [REG_W-1:0] result,
  output logic result_valid,
  output faco_flags_s arith_status,
  output faco_sticky_s sticky_status
);

  // ----------------------------------------
  // operand classification
  // ----------------------------------------
  faco_state_s st_ff;
  faco_state_s nxt_st;
  faco_fp_s x;
  logic x_nan;
  logic x_inf;
  logic x_zero;

  assign x = opnd_x;
  assign x_nan = (x.exp == EXP_INF) && (x.frac != 31'h0000_0000);
  assign x_inf = (x.exp == EXP_INF) && (x.frac == 31'h0000_0000);
  assign x_zero = (x.exp == 8'h00);

  // ----------------------------------------
  // arithmetic paths
  // ----------------------------------------
  logic rnd_inc;
  logic [23:0] rnd_sum;
  logic [8:0] rnd_exp;
  logic [33:0] scl_exp;
  logic scl_ovf;
  logic scl_under;
  logic [9:0] unb_exp;
  logic [63:0] fix_sh;
  logic [31:0] fix_int;
  logic fix_half;
  logic fix_sticky;
  logic fix_inc;
  logic [32:0] fix_mag;
  logic fix_big;
  logic fix_ovf;
  logic [31:0] fix_val;
  logic [REG_W-1:0] res;
  faco_flags_s fl;
  faco_sticky_s sticky_set;

  always_comb
  begin
    // truncation when the boundary select is high, otherwise round-half-even
    rnd_inc = !round_boundary_sel && x.frac[7] && ((|x.frac[6:0]) || x.frac[8]);
    rnd_sum = {1'b0, x.frac[30:8]} + {23'h00_0000, rnd_inc};
    rnd_exp = {1'b0, x.exp} + {8'h00, rnd_sum[23]};
    scl_exp = {26'h000_0000, x.exp} + {{2{opnd_y[39]}}, opnd_y[39:8]};
    scl_ovf = !scl_exp[33] && (scl_exp[32:0] >= 33'h0_0000_00FF);
    scl_under = scl_exp[33] || (scl_exp == 34'h0_0000_0000);
    unb_exp = {2'b00, x.exp} - EXP_BIAS;
    // only used for exponents 0..30 unbiased, so five shift bits suffice
    fix_sh = {32'h0000_0000, 1'b1, x.frac} << unb_exp[4:0];
    fix_int = fix_sh[62:31];
    fix_half = fix_sh[30];
    fix_sticky = |fix_sh[29:0];
    if (round_to_zero_sel)
    begin
      fix_inc = x.sign && (fix_half || fix_sticky);
    end
    else
    begin
      fix_inc = fix_half && (fix_sticky || fix_int[0]);
    end
    fix_mag = {1'b0, fix_int} + {32'h0000_0000, fix_inc};
    fix_big = ({2'b00, x.exp} > FIX_OVF_EXP);
    fix_ovf = fix_big || (x.sign ? (fix_mag > {1'b0, SAT_NEG}) : (fix_mag > {1'b0, SAT_POS}));
    fix_val = x.sign ? (32'h0000_0000 - fix_mag[31:0]) : fix_mag[31:0];
  end

  // ----------------------------------------
  // result and flag selection
  // ----------------------------------------
  always_comb
  begin
    res = RESULT_RST;
    fl = FLAGS_RST;
    case (op_code)
      FACO_OP_RND:
      begin
        if (x_nan)
        begin
          res = ALL_ONES;
          fl.invalid_flag = 1'b1;
        end
        else if (x_zero)
        begin
          res = {x.sign, 39'h00_0000_0000};
          fl.zero_flag = 1'b1;
        end
        else if (x_inf)
        begin
          res = {x.sign, EXP_INF, 31'h0000_0000};
          fl.negative_flag = x.sign;
        end
        else if (rnd_exp >= {1'b0, EXP_INF})
        begin
          fl.overflow_flag = 1'b1;
          fl.negative_flag = x.sign;
          if (round_boundary_sel)
          begin
            res = {x.sign, EXP_LARGEST_NORMAL_VALUE, FRAC_LARGEST_NORMAL_VALUE};
          end
          else
          begin
            res = {x.sign, EXP_INF, 31'h0000_0000};
          end
        end
        else
        begin
          res = {x.sign, rnd_exp[7:0], rnd_sum[22:0], 8'h00};
          fl.negative_flag = x.sign;
        end
      end
      FACO_OP_SCALB:
      begin
        if (x_nan)
        begin
          res = ALL_ONES;
          fl.invalid_flag = 1'b1;
        end
        else if (x_zero || (!x_inf && !scl_ovf && scl_under))
        begin
          res = {x.sign, 39'h00_0000_0000};
          fl.zero_flag = 1'b1;
        end
        else if (x_inf)
        begin
          res = {x.sign, EXP_INF, 31'h0000_0000};
          fl.negative_flag = x.sign;
        end
        else if (scl_ovf)
        begin
          fl.overflow_flag = 1'b1;
          fl.negative_flag = x.sign;
          if (round_to_zero_sel)
          begin
            res = {x.sign, EXP_LARGEST_NORMAL_VALUE, FRAC_LARGEST_NORMAL_VALUE};
          end
          else
          begin
            res = {x.sign, EXP_INF, 31'h0000_0000};
          end
        end
        else
        begin
          res = {x.sign, scl_exp[7:0], x.frac};
          fl.negative_flag = x.sign;
        end
      end
      FACO_OP_MANT:
      begin
        fl.sign_flag = x.sign;
        if (x_nan || x_inf)
        begin
          res = ALL_ONES;
          fl.invalid_flag = x_nan;
          fl.overflow_flag = x_inf;
        end
        else if (x_zero)
        begin
          fl.zero_flag = 1'b1;
        end
        else
        begin
          res = {1'b1, x.frac, 8'h00};
        end
      end
      FACO_OP_LOGB:
      begin
        if (x_nan)
        begin
          res = ALL_ONES;
          fl.invalid_flag = 1'b1;
        end
        else
        begin
          if (x_inf)
          begin
            fl.overflow_flag = 1'b1;
            if (alu_saturate_en)
            begin
              res = {SAT_POS, 8'h00};
            end
            else
            begin
              res = {1'b0, EXP_INF, 31'h0000_0000};
            end
          end
          else if (x_zero)
          begin
            fl.overflow_flag = 1'b1;
            if (alu_saturate_en)
            begin
              res = {SAT_NEG, 8'h00};
            end
            else
            begin
              res = {1'b1, EXP_INF, 31'h0000_0000};
            end
          end
          else
          begin
            res = {{22{unb_exp[9]}}, unb_exp, 8'h00};
          end
          fl.negative_flag = res[39];
          fl.zero_flag = (res[39:8] == 32'h0000_0000);
        end
      end
      FACO_OP_FIX:
      begin
        if (x_nan)
        begin
          res = ALL_ONES;
          fl.invalid_flag = 1'b1;
        end
        else
        begin
          if (x_zero)
          begin
            res = RESULT_RST;
          end
          else if (x_inf || (fix_ovf && !unb_exp[9]))
          begin
            fl.overflow_flag = 1'b1;
            if (alu_saturate_en)
            begin
              res = {(x.sign ? SAT_NEG : SAT_POS), 8'h00};
            end
            else
            begin
              res = ALL_ONES;
              fl.invalid_flag = 1'b1;
            end
          end
          else if (unb_exp[9])
          begin
            // magnitude below one rounds up to one here only for a negative input under truncation
            res = (x.sign && round_to_zero_sel) ? NEG_UNDER_TRUNC : RESULT_RST;
          end
          else
          begin
            res = {fix_val, 8'h00};
          end
          fl.negative_flag = res[39];
          fl.zero_flag = (res[39:8] == 32'h0000_0000);
        end
      end
      default:
      begin
        res = RESULT_RST;
      end
    endcase
  end

  // ----------------------------------------
  // state update
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.valid = 1'b0;
    sticky_set = STICKY_RST;
    sticky_set.sticky_invalid = op_valid && fl.invalid_flag;
    sticky_set.sticky_overflow = op_valid && fl.overflow_flag && (op_code != FACO_OP_FIX);
    sticky_set.sticky_underflow = op_valid && fl.zero_flag && (op_code == FACO_OP_SCALB);
    if (op_valid)
    begin
      nxt_st.result = res;
      nxt_st.flags = fl;
      nxt_st.valid = 1'b1;
    end
    // a new event in the clear cycle survives the clear
    nxt_st.sticky = (sticky_clr ? faco_sticky_s'(STICKY_RST) : st_ff.sticky) | sticky_set;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= '{result: RESULT_RST, valid: 1'b0, flags: FLAGS_RST, sticky: STICKY_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign result = st_ff.result;
  assign result_valid = st_ff.valid;
  assign arith_status = st_ff.flags;
  assign sticky_status = st_ff.sticky;

endmodule

//--- tb/faco_regfile_model.sv
// Purpose: register-file side that stores what the slice hands back
// Assumes: one destination write per result_valid pulse
// Notes: write count lets the bench spot a missing or doubled write
`timescale 1ns/1ps
module faco_regfile_model
  import faco_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic result_valid,
  input wire logic [REG_W-1:0] result,
  input wire faco_flags_s arith_status,
  output logic [REG_W-1:0] dest_ff,
  output faco_flags_s flags_ff,
  output int writes_ff
);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dest_ff <= RESULT_RST;
      flags_ff <= FLAGS_RST;
      writes_ff <= 0;
    end
    else if (result_valid)
    begin
      dest_ff <= result;
      flags_ff <= arith_status;
      writes_ff <= writes_ff + 1;
    end
  end
endmodule

//--- tb/faco_properties.sv
// Purpose: port-level timing and value checks on the convert-op slice
// Assumes: only one-hot op codes are issued
// Notes: bound to faco_top below
`timescale 1ns/1ps
module faco_properties
  import faco_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic op_valid,
  input wire faco_op_e op_code,
  input wire logic [REG_W-1:0] opnd_x,
  input wire logic [REG_W-1:0] opnd_y,
  input wire logic round_boundary_sel,
  input wire logic round_to_zero_sel,
  input wire logic alu_saturate_en,
  input wire logic sticky_clr,
  input wire logic [REG_W-1:0] result,
  input wire logic result_valid,
  input wire faco_flags_s arith_status,
  input wire faco_sticky_s sticky_status
);
  logic [7:0] xe;
  logic inf_in;
  assign xe = opnd_x[38:31];
  assign inf_in = xe == EXP_INF && opnd_x[30:0] == '0;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence taken(faco_op_e c);
    op_valid && op_code == c;
  endsequence
  sequence normal_in;
    xe != 8'h00 && xe != EXP_INF;
  endsequence
  valid_pulse_a: assert property (op_valid |=> result_valid)
    else $error("no result one cycle after op");
  idle_hold_a: assert property (!op_valid |=> !result_valid && $stable(result)
    && $stable(arith_status)) else $error("outputs moved with no op");
  nan_ones_a: assert property (op_valid && $onehot(op_code) && xe == EXP_INF
    && opnd_x[30:0] != '0 |=> result == ALL_ONES && arith_status.invalid_flag)
    else $error("nan input not all ones");
  mant_frac_a: assert property (taken(FACO_OP_MANT) ##0 normal_in |=>
    result == {1'h1, $past(opnd_x[30:0]), 8'h00} && !arith_status.negative_flag
    && arith_status.sign_flag == $past(opnd_x[39])) else $error("mantissa wrong");
  logb_unbias_a: assert property (taken(FACO_OP_LOGB) ##0 normal_in |=>
    result[39:8] == {24'h000000, $past(xe)} - 32'h0000_007F) else $error("logb wrong");
  logb_sat_a: assert property (taken(FACO_OP_LOGB) ##0 alu_saturate_en && inf_in
    |=> result == {SAT_POS, 8'h00} && arith_status.overflow_flag)
    else $error("logb saturated infinity wrong");
  fix_sat_a: assert property (taken(FACO_OP_FIX) ##0 alu_saturate_en && !opnd_x[39]
    && xe > FIX_OVF_EXP && xe != EXP_INF |=> result == {SAT_POS, 8'h00}
    && arith_status.overflow_flag) else $error("fix positive overflow wrong");
  sticky_inv_a: assert property (result_valid && arith_status.invalid_flag
    |-> sticky_status.sticky_invalid) else $error("sticky invalid not latched");
  sticky_und_a: assert property (taken(FACO_OP_SCALB) ##1 arith_status.zero_flag
    |-> sticky_status.sticky_underflow) else $error("sticky underflow not latched");
endmodule
bind faco_top faco_properties u_props (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid),
  .op_code(op_code), .opnd_x(opnd_x), .opnd_y(opnd_y),
  .round_boundary_sel(round_boundary_sel), .round_to_zero_sel(round_to_zero_sel),
  .alu_saturate_en(alu_saturate_en), .sticky_clr(sticky_clr), .result(result),
  .result_valid(result_valid), .arith_status(arith_status), .sticky_status(sticky_status));

//--- tb/tb_top.sv
// Purpose: directed bench for the float convert-op slice
// Assumes: inputs change on the falling edge
// Notes: mode argument is {boundary, to_zero, saturate}
`timescale 1ns/1ps
module tb_top;
  import faco_pkg::*;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic op_valid = 1'h0;
  faco_op_e op_code = FACO_OP_RND;
  logic [REG_W-1:0] opnd_x = '0;
  logic [REG_W-1:0] opnd_y = '0;
  logic rbs = 1'h0;
  logic rtz = 1'h0;
  logic sat = 1'h0;
  logic sticky_clr = 1'h0;
  logic [REG_W-1:0] result;
  logic result_valid;
  faco_flags_s arith_status;
  faco_sticky_s sticky_status;
  logic [REG_W-1:0] rf_data;
  faco_flags_s rf_flags;
  int rf_writes;
  int errors = 0;
  int n_checks = 0;
  faco_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .opnd_x(opnd_x), .opnd_y(opnd_y), .round_boundary_sel(rbs), .round_to_zero_sel(rtz),
    .alu_saturate_en(sat), .sticky_clr(sticky_clr), .result(result),
    .result_valid(result_valid), .arith_status(arith_status), .sticky_status(sticky_status));
  faco_regfile_model u_rf (.clk_sys(clk_sys), .rstn(rstn), .result_valid(result_valid),
    .result(result), .arith_status(arith_status), .dest_ff(rf_data), .flags_ff(rf_flags),
    .writes_ff(rf_writes));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic op(input faco_op_e c, input logic [39:0] x, input logic [39:0] y,
      input logic [2:0] m, input logic [39:0] er, input logic [5:0] ef,
      input logic [5:0] mk = 6'h3F);
    int w;
    @(negedge clk_sys);
    w = rf_writes;
    op_valid = 1'h1;
    op_code = c;
    opnd_x = x;
    opnd_y = y;
    {rbs, rtz, sat} = m;
    @(negedge clk_sys);
    op_valid = 1'h0;
    chk(result_valid === 1'h1, "no result_valid");
    @(negedge clk_sys);
    chk(rf_writes == w + 1 && rf_data === er && (rf_flags & mk) === (ef & mk),
      $sformatf("x=%h got %h flags %h", x, rf_data, rf_flags));
  endtask
  task automatic stk(input logic [3:0] e);
    chk(sticky_status === e, $sformatf("sticky %h", sticky_status));
  endtask
  task automatic clr();
    @(negedge clk_sys);
    sticky_clr = 1'h1;
    @(negedge clk_sys);
    sticky_clr = 1'h0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #200000;
    chk(1'h0, "watchdog expired");
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'h1;
    stk(4'h0);
    chk(result === RESULT_RST, "result not cleared by reset");
    op(FACO_OP_FIX, 40'h3F_C000_0000, '0, 3'h0, 40'h00_0000_0200, 6'h00);
    op(FACO_OP_FIX, 40'h3F_C000_0000, '0, 3'h2, 40'h00_0000_0100, 6'h00);
    op(FACO_OP_FIX, 40'hBF_0000_0000, '0, 3'h2, 40'hFF_FFFF_FF00, 6'h08);
    op(FACO_OP_FIX, 40'hBF_0000_0000, '0, 3'h0, 40'h00_0000_0000, 6'h01);
    op(FACO_OP_FIX, 40'h3F_4000_0000, '0, 3'h0, 40'h00_0000_0000, 6'h01);
    op(FACO_OP_FIX, 40'h4E_8000_0000, '0, 3'h1, 40'h40_0000_0000, 6'h00);
    op(FACO_OP_FIX, 40'h4F_0000_0000, '0, 3'h1, 40'h7F_FFFF_FF00, 6'h02);
    op(FACO_OP_FIX, 40'hFF_8000_0000, '0, 3'h1, 40'h80_0000_0000, 6'h0A);
    stk(4'h0);
    op(FACO_OP_FIX, 40'h7F_8000_0000, '0, 3'h0, ALL_ONES, 6'h12, 6'h12);
    op(FACO_OP_FIX, 40'h7F_C000_0000, '0, 3'h0, ALL_ONES, 6'h10);
    stk(4'h2);
    op(FACO_OP_LOGB, 40'hBF_0000_0000, '0, 3'h0, 40'hFF_FFFF_FF00, 6'h08);
    op(FACO_OP_LOGB, 40'h00_0000_0000, '0, 3'h0, 40'hFF_8000_0000, 6'h0A);
    op(FACO_OP_LOGB, 40'h7F_8000_0000, '0, 3'h0, 40'h7F_8000_0000, 6'h02);
    op(FACO_OP_LOGB, 40'h00_0000_0001, '0, 3'h1, 40'h80_0000_0000, 6'h0A);
    op(FACO_OP_LOGB, 40'h7F_8000_0000, '0, 3'h1, 40'h7F_FFFF_FF00, 6'h02);
    op(FACO_OP_MANT, 40'hBF_C000_0000, '0, 3'h6, 40'hC0_0000_0000, 6'h04);
    op(FACO_OP_MANT, 40'h7F_8000_0000, '0, 3'h0, ALL_ONES, 6'h02);
    op(FACO_OP_RND, 40'h3F_C000_0081, '0, 3'h0, 40'h3F_C000_0100, 6'h00);
    op(FACO_OP_RND, 40'h3F_C000_0081, '0, 3'h4, 40'h3F_C000_0000, 6'h00);
    clr();
    op(FACO_OP_RND, 40'hFF_7FFF_FFFF, '0, 3'h0, 40'hFF_8000_0000, 6'h0A);
    stk(4'h1);
    op(FACO_OP_RND, 40'hFF_7FFF_FFFF, '0, 3'h4, 40'hFF_7FFF_FF00, 6'h08);
    op(FACO_OP_RND, 40'h80_0000_0005, '0, 3'h0, 40'h80_0000_0000, 6'h01);
    op(FACO_OP_SCALB, 40'h3F_C000_0000, 40'h00_0000_0300, 3'h0, 40'h41_4000_0000, 6'h00);
    op(FACO_OP_SCALB, 40'h3F_C000_0000, 40'h00_0000_C800, 3'h2,
      {1'h0, EXP_LARGEST_NORMAL_VALUE, FRAC_LARGEST_NORMAL_VALUE}, 6'h02);
    op(FACO_OP_SCALB, 40'h3F_C000_0000, 40'h00_0000_C800, 3'h0, 40'h7F_8000_0000, 6'h02);
    clr();
    op(FACO_OP_SCALB, 40'h3F_C000_0000, 40'hFF_FFFF_8200, 3'h0, 40'h00_C000_0000, 6'h00);
    stk(4'h0);
    op(FACO_OP_SCALB, 40'h3F_C000_0000, 40'hFF_FFFF_8100, 3'h0, 40'h00_0000_0000, 6'h01);
    stk(4'h8);
    report_and_stop();
  end
endmodule
